// >>> radio_power_pkg.sv
package radio_power_pkg;

  // ************************************************************
  // Command word layout
  // ************************************************************
  localparam logic [7:0]  CFG_CODE        = 8'h80;
  localparam logic [7:0]  PWR_CODE        = 8'h82;
  localparam logic [7:0]  STATUS_CODE     = 8'h00;
  localparam logic [15:0] CFG_RESET       = 16'h8008;
  localparam logic [15:0] PWR_RESET       = 16'h8208;

  // Configuration field positions
  localparam int CFG_TXREG_BIT  = 7;
  localparam int CFG_FIFO_BIT   = 6;
  localparam int CFG_BAND_LSB   = 4;
  localparam int CFG_TRIM_LSB   = 0;

  // Power field positions
  localparam int PWR_RX_BIT     = 7;
  localparam int PWR_BB_BIT     = 6;
  localparam int PWR_TX_BIT     = 5;
  localparam int PWR_SYN_BIT    = 4;
  localparam int PWR_XO_BIT     = 3;
  localparam int PWR_LBD_BIT    = 2;
  localparam int PWR_WKT_BIT    = 1;
  localparam int PWR_CKOFF_BIT  = 0;

  // Clock tail length in output clock pulses
  localparam logic [7:0] TAIL_PULSES = 8'hc0;

  // Crystal load: 8.5 pF base, 0.5 pF step, in tenths of pF
  localparam logic [7:0] TRIM_BASE_DPF = 8'h55;
  localparam logic [7:0] TRIM_STEP_DPF = 8'h05;

  typedef enum logic [1:0] {
    BAND_RSVD = 2'h0,
    BAND_433  = 2'h1,
    BAND_868  = 2'h2,
    BAND_915  = 2'h3
  } band_t;

  // Decoded block enables
  typedef struct packed {
    logic xtal;
    logic synth;
    logic baseband;
    logic rf_front;
    logic pa;
    logic tx_start;
    logic lbd;
    logic wake;
    logic bb_skip_cal;
  } enables_t;

endpackage

// >>> radio_power_config_control.sv
`timescale 1ns/1ps
// Contract
// - Reset loads 8008h and 8208h defaults
// - TX data register enabled by its bit
// - FIFO mode else data pins output
// - Band select decodes 433/868/915
// - Crystal trim 8.5 to 16.0 pF
// - RX path forces xtal, synth, baseband, front
// - TX path forces xtal, synth, PA; start only with TX register bit
// - Both paths set means receive mode
// - Baseband needs synthesizer and oscillator
// - Synthesizer implies oscillator enable
// - Battery detector and wake timer enables
// - Clock output off while bit set
// - Clearing oscillator gives 192 tail pulses
// - Tail only after a prior status read
// - Pending interrupt forces oscillator on
// - Interrupts cleared plus status read: auto off
// - Active interrupt blocks oscillator shutdown
// - Clock off disables tail and auto control
// - Baseband already on skips calibration
// - Serial words arrive assembled MSB first
// - Interrupt output low on pending events
module radio_power_config_control (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_out_clk,
  input  wire logic                       cmd_valid,
  input  wire logic [15:0]                cmd_word,
  input  wire logic [4:0]                 irq_events,
  output logic                            int_request_n,
  output logic [15:0]                     status_word,
  output logic                            tx_data_reg_enable,
  output logic                            rx_fifo_enable,
  output logic                            data_pins_enable,
  output radio_power_pkg::band_t          band_select,
  output logic [7:0]                      xtal_load_dpf,
  output radio_power_pkg::enables_t       block_en,
  output logic                            clk_out_enable
);

  // ************************************************************
  // Command registers
  // ************************************************************
  logic [7:0] cfg_reg;
  logic [7:0] pwr_reg;
  logic       is_cfg;
  logic       is_pwr;
  logic       is_status;

  assign is_cfg    = cmd_valid && cmd_word[15:8] == radio_power_pkg::CFG_CODE;
  assign is_pwr    = cmd_valid && cmd_word[15:8] == radio_power_pkg::PWR_CODE;
  assign is_status = cmd_valid &&
                     cmd_word[15:8] == radio_power_pkg::STATUS_CODE;

  // Words arrive already assembled MSB first by the serial shifter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_reg <= radio_power_pkg::CFG_RESET[7:0];
      pwr_reg <= radio_power_pkg::PWR_RESET[7:0];
    end else begin
      if (is_cfg) begin
        cfg_reg <= cmd_word[7:0];
      end
      if (is_pwr) begin
        pwr_reg <= cmd_word[7:0];
      end
    end
  end

  logic rx_on;
  logic tx_on;
  logic bb_bit;
  logic syn_bit;
  logic xo_bit;
  logic ck_off;

  assign rx_on   = pwr_reg[radio_power_pkg::PWR_RX_BIT];
  assign bb_bit  = pwr_reg[radio_power_pkg::PWR_BB_BIT];
  assign tx_on   = pwr_reg[radio_power_pkg::PWR_TX_BIT];
  assign syn_bit = pwr_reg[radio_power_pkg::PWR_SYN_BIT];
  assign xo_bit  = pwr_reg[radio_power_pkg::PWR_XO_BIT];
  assign ck_off  = pwr_reg[radio_power_pkg::PWR_CKOFF_BIT];

  // ************************************************************
  // Interrupt flags
  // ************************************************************
  // Bit 4 is the power-on flag, set by reset itself
  logic [4:0] irq_reg;
  logic       irq_any;

  // Set wins over a clearing status read in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_reg <= 5'h10;
    end else if (is_status) begin
      irq_reg <= irq_events;
    end else begin
      irq_reg <= irq_reg | irq_events;
    end
  end

  assign irq_any = |irq_reg;

  // Status capture shows flags as they stood before the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_word <= 16'h0000;
    end else if (is_status) begin
      status_word <= {irq_reg, 11'h000};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_request_n <= 1'b1;
    end else begin
      int_request_n <= ~irq_any;
    end
  end

  // ************************************************************
  // Oscillator control and clock tail
  // ************************************************************
  // Tail armed by a status read, spent by the next oscillator drop
  logic armed_reg;
  logic xo_want;
  logic xo_want_d;
  logic tail_start;
  logic tail_tgl_reg;

  // Oscillator request before any tail is applied
  always_comb begin
    xo_want = xo_bit || syn_bit || rx_on || tx_on;
    if (!ck_off && irq_any) begin
      xo_want = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      xo_want_d <= 1'b1;
    end else begin
      xo_want_d <= xo_want;
    end
  end

  // Falling request with tail armed and clock output in use
  assign tail_start = xo_want_d && !xo_want && armed_reg && !ck_off;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (is_status) begin
      armed_reg <= 1'b1;
    end else if (xo_want_d && !xo_want) begin
      armed_reg <= 1'b0;
    end
  end

  // Event crosses to the clock output domain as a toggle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tail_tgl_reg <= 1'b0;
    end else if (tail_start) begin
      tail_tgl_reg <= ~tail_tgl_reg;
    end
  end

  // ************************************************************
  // Clock output domain: tail counter
  // ************************************************************
  // The oscillator clock runs free while the tail counts
  logic       tg_s1;
  logic       tg_s2;
  logic       tg_s3;
  logic [7:0] tail_cnt;
  logic       tail_busy_reg;
  logic       lrst_s1;
  logic       lrst_s2;

  always_ff @(posedge clk_out_clk) begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
  end

  always_ff @(posedge clk_out_clk) begin
    if (lrst_s2) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= tail_tgl_reg;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  // Counts the pulses still owed on the clock output
  always_ff @(posedge clk_out_clk) begin
    if (lrst_s2) begin
      tail_cnt      <= 8'h00;
      tail_busy_reg <= 1'b0;
    end else if (tg_s2 != tg_s3) begin
      tail_cnt      <= radio_power_pkg::TAIL_PULSES;
      tail_busy_reg <= 1'b1;
    end else if (tail_cnt != 8'h00) begin
      tail_cnt      <= tail_cnt - 8'h01;
      tail_busy_reg <= tail_cnt != 8'h01;
    end
  end

  // Busy level back to the core domain
  logic tb_s1;
  logic tb_s2;
  logic tail_pend_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tb_s1 <= 1'b0;
      tb_s2 <= 1'b0;
    end else begin
      tb_s1 <= tail_busy_reg;
      tb_s2 <= tb_s1;
    end
  end

  // Covers the crossing latency until busy is seen
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tail_pend_reg <= 1'b0;
    end else if (tail_start) begin
      tail_pend_reg <= 1'b1;
    end else if (tb_s2) begin
      tail_pend_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Decoded outputs
  // ************************************************************
  logic     xo_final;
  logic     syn_final;
  logic     bb_final;
  logic     rx_mode;
  logic     bb_was_on;

  assign rx_mode   = rx_on;
  // Tail start itself keeps the oscillator up, else a one-cycle dropout
  assign xo_final  = xo_want || tail_start ||
                     tail_pend_reg || tb_s2;
  assign syn_final = (syn_bit || rx_on || tx_on || bb_bit) && xo_final;
  assign bb_final  = (bb_bit || rx_on) && syn_final;

  // Baseband state frozen on entry to receive, so skip marks the entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bb_was_on <= 1'b0;
    end else if (!rx_mode) begin
      bb_was_on <= bb_final;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      block_en <= '0;
    end else begin
      block_en.xtal        <= xo_final;
      block_en.synth       <= syn_final;
      block_en.baseband    <= bb_final;
      block_en.rf_front    <= rx_mode;
      block_en.pa          <= tx_on && !rx_mode;
      block_en.tx_start    <= tx_on && !rx_mode &&
                              cfg_reg[radio_power_pkg::CFG_TXREG_BIT];
      block_en.lbd         <= pwr_reg[radio_power_pkg::PWR_LBD_BIT];
      block_en.wake        <= pwr_reg[radio_power_pkg::PWR_WKT_BIT];
      block_en.bb_skip_cal <= rx_mode && bb_was_on;
    end
  end

  // Configuration outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_data_reg_enable <= 1'b0;
      rx_fifo_enable     <= 1'b0;
      data_pins_enable   <= 1'b1;
      band_select        <= radio_power_pkg::BAND_RSVD;
      xtal_load_dpf      <= radio_power_pkg::TRIM_BASE_DPF;
      clk_out_enable     <= 1'b1;
    end else begin
      tx_data_reg_enable <= cfg_reg[radio_power_pkg::CFG_TXREG_BIT];
      rx_fifo_enable     <= cfg_reg[radio_power_pkg::CFG_FIFO_BIT];
      data_pins_enable   <= ~cfg_reg[radio_power_pkg::CFG_FIFO_BIT];
      band_select        <= radio_power_pkg::band_t'(
                              cfg_reg[radio_power_pkg::CFG_BAND_LSB +: 2]);
      xtal_load_dpf      <= radio_power_pkg::TRIM_BASE_DPF +
                            8'(cfg_reg[3:0] *
                               radio_power_pkg::TRIM_STEP_DPF);
      clk_out_enable     <= ~ck_off && xo_final;
    end
  end
  // Band code passes straight through the enum
  // Low battery and wake timer follow their bits directly

endmodule // radio_power_config_control

// >>> radio_power_props.sv
`timescale 1ns/1ps
module radio_power_props (
  input logic                      core_clk,
  input logic                      sys_rst,
  input logic                      cmd_valid,
  input logic [15:0]               cmd_word,
  input logic                      int_request_n,
  input logic                      tx_data_reg_enable,
  input logic                      rx_fifo_enable,
  input logic                      data_pins_enable,
  input radio_power_pkg::band_t    band_select,
  input logic [7:0]                xtal_load_dpf,
  input radio_power_pkg::enables_t block_en,
  input logic                      clk_out_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic        cfg_wr;
  logic        pwr_wr;
  logic [15:0] w_q1;
  logic [15:0] w_q2;
  // Word delayed to line up with decoded outputs
  always_ff @(posedge core_clk) begin
    w_q1 <= cmd_word;
    w_q2 <= w_q1;
  end
  assign cfg_wr = cmd_valid && cmd_word[15:8] == 8'h80;
  assign pwr_wr = cmd_valid && cmd_word[15:8] == 8'h82;
  txreg_en_a: assert property (cfg_wr |-> ##2 tx_data_reg_enable == w_q2[7])
    else $error("tx register enable wrong");
  fifo_mode_a: assert property (cfg_wr |-> ##2 rx_fifo_enable == w_q2[6]
    && data_pins_enable == !w_q2[6]) else $error("fifo mode wrong");
  band_dec_a: assert property (cfg_wr |-> ##2 band_select == w_q2[5:4])
    else $error("band wrong");
  trim_map_a: assert property (cfg_wr |-> ##2
    xtal_load_dpf == 8'h55 + 8'h05 * w_q2[3:0]) else $error("trim wrong");
  rx_path_a: assert property (pwr_wr && cmd_word[7] |-> ##2
    block_en.xtal && block_en.synth && block_en.baseband
    && block_en.rf_front && !block_en.pa) else $error("rx path wrong");
  tx_path_a: assert property (pwr_wr && cmd_word[5] && !cmd_word[7]
    |-> ##2 block_en.xtal && block_en.synth && block_en.pa)
    else $error("tx path wrong");
  power_chain_a: assert property ((!block_en.baseband || block_en.synth)
    && (!block_en.synth || block_en.xtal)) else $error("chain broken");
  aux_en_a: assert property (pwr_wr |-> ##2 block_en.lbd == w_q2[2]
    && block_en.wake == w_q2[1]) else $error("aux enable wrong");
  clk_off_a: assert property (pwr_wr && cmd_word[0] |-> ##2
    !clk_out_enable && block_en.xtal == |{w_q2[7], w_q2[5:3]})
    else $error("clock off wrong");
  irq_hold_a: assert property (pwr_wr && !cmd_word[0] && !int_request_n
    ##1 !int_request_n |-> ##1 block_en.xtal) else $error("osc not forced");
  rx_cov: cover property (pwr_wr && cmd_word[7]);
  cfg_cov: cover property (cfg_wr);
  tail_cov: cover property ($fell(clk_out_enable));
endmodule // radio_power_props

bind radio_power_config_control radio_power_props i_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_word(cmd_word), .int_request_n(int_request_n),
  .tx_data_reg_enable(tx_data_reg_enable), .rx_fifo_enable(rx_fifo_enable),
  .data_pins_enable(data_pins_enable), .band_select(band_select),
  .xtal_load_dpf(xtal_load_dpf), .block_en(block_en),
  .clk_out_enable(clk_out_enable));

// >>> radio_host_model.sv
`timescale 1ns/1ps
module radio_host_model (
  input  logic        core_clk,
  output logic        cmd_valid,
  output logic [15:0] cmd_word,
  output logic [4:0]  irq_events
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    irq_events = 5'h00;
  end
  // Whole word, MSB-first shift already done; released word is garbled
  task automatic send(input logic [15:0] w);
    @(posedge core_clk);
    #2 cmd_valid = 1'b1;
    cmd_word = w;
    @(posedge core_clk);
    #2 cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask
  // One-cycle event from another source
  task automatic pulse(input logic [4:0] e);
    @(posedge core_clk);
    #2 irq_events = e;
    @(posedge core_clk);
    #2 irq_events = 5'h00;
  endtask
endmodule // radio_host_model

// >>> radio_power_config_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t mismatch", $time); end end
module radio_power_config_control_tb_top;
  logic                      core_clk = 1'b0;
  logic                      clk_out_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      cmd_valid, int_request_n, tx_data_reg_enable;
  logic                      rx_fifo_enable, data_pins_enable, clk_out_enable;
  logic [15:0]               cmd_word, status_word;
  logic [4:0]                irq_events;
  logic [7:0]                xtal_load_dpf, m;
  logic                      pbb;
  radio_power_pkg::band_t    band_select;
  radio_power_pkg::enables_t block_en, e;
  int                        fail_count = 0, checks = 0, cyc = 0, n;
  logic [7:0] modes [7] = '{8'h81, 8'h21, 8'ha1, 8'h51, 8'h81, 8'h0f, 8'h01};
  // ************************************************************
  // Clocks, timeout and verdict
  // ************************************************************
  always #12.5 core_clk = ~core_clk;
  initial begin
    #7;
    forever #40 clk_out_clk = ~clk_out_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic results;
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  radio_host_model i_host (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .irq_events(irq_events));
  radio_power_config_control i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_out_clk(clk_out_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .irq_events(irq_events), .int_request_n(int_request_n),
    .status_word(status_word), .tx_data_reg_enable(tx_data_reg_enable),
    .rx_fifo_enable(rx_fifo_enable), .data_pins_enable(data_pins_enable),
    .band_select(band_select), .xtal_load_dpf(xtal_load_dpf),
    .block_en(block_en), .clk_out_enable(clk_out_enable));
  // ************************************************************
  // Helpers
  // ************************************************************
  // Decoded outputs land one edge after the taking edge
  task automatic cmd(input logic [15:0] w);
    i_host.send(w);
    repeat (2) @(posedge core_clk);
    #3;
  endtask
  // Counts link-clock pulses until the clock output stops
  task automatic tail(output int k);
    k = 0;
    while (clk_out_enable === 1'b1 && k < 400) begin
      @(posedge clk_out_clk);
      k++;
    end
    #60;
  endtask
  function automatic radio_power_pkg::enables_t exp_en(
      input logic [7:0] p, input logic pb);
    radio_power_pkg::enables_t r;
    r.rf_front = p[7];
    r.pa = p[5] & ~p[7];
    r.synth = p[7] | p[5] | p[4];
    r.xtal = r.synth | p[3];
    r.baseband = p[7] | (p[6] & r.synth);
    r.tx_start = r.pa;
    r.lbd = p[2];
    r.wake = p[1];
    r.bb_skip_cal = p[7] & pb;
    return r;
  endfunction
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    // Longer than two cycles so the link domain also sees reset
    repeat (10) @(posedge core_clk);
    #2 sys_rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #3;
    `CHK(xtal_load_dpf, 8'h7d);
    `CHK({tx_data_reg_enable, rx_fifo_enable, data_pins_enable}, 3'h1);
    `CHK(band_select, radio_power_pkg::BAND_RSVD);
    `CHK(block_en, 9'h100);
    `CHK({clk_out_enable, int_request_n}, 2'h2);
    cmd(16'h0000);
    `CHK(status_word, 16'h8000);
    `CHK(int_request_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cmd({8'h80, 2'(i), (i == 0) ? 2'h1 : 2'(i), 4'(i * 5)});
      `CHK({tx_data_reg_enable, rx_fifo_enable}, 2'(i));
      `CHK(data_pins_enable, ~rx_fifo_enable);
      `CHK(band_select, (i == 0) ? 2'h1 : 2'(i));
      `CHK(xtal_load_dpf, 8'h55 + 8'(i * 25));
    end
    pbb = 1'b0;
    foreach (modes[k]) begin
      m = modes[k];
      cmd({8'h82, m});
      e = exp_en(m, pbb);
      `CHK(block_en, e);
      `CHK(clk_out_enable, 1'b0);
      pbb = e.baseband;
    end
    cmd(16'h8200);
    i_host.pulse(5'h01);
    repeat (2) @(posedge core_clk);
    #3;
    `CHK({int_request_n, block_en.xtal, clk_out_enable}, 3'h3);
    cmd(16'h8200);
    `CHK(block_en.xtal, 1'b1);
    i_host.send(16'h0000);
    #30;
    `CHK(status_word, 16'h0800);
    tail(n);
    `CHK(n >= 192 && n <= 200, 1'b1);
    `CHK(block_en.xtal, 1'b0);
    cmd(16'h8208);
    cmd(16'h8200);
    `CHK({clk_out_enable, block_en.xtal}, 2'h0);
    cmd(16'h8208);
    cmd(16'h0000);
    i_host.send(16'h8200);
    tail(n);
    `CHK(n >= 192 && n <= 200, 1'b1);
    results();
  end
endmodule // radio_power_config_control_tb_top
